// ### src/sfb_pkg.sv
// Shared constants for the register bank, clock generator and timers 0/1.
// Assumes one oscillator clock and direct addressing in the 0x80..0xff window.
package sfb_pkg;

  // Oscillator periods per machine cycle and the phase counter that makes them
  localparam int         OSC_PER_MCYCLE_STD = 12;
  localparam int         OSC_PER_MCYCLE_X2  = 6;
  localparam logic [2:0] PHASE_LAST         = 3'(OSC_PER_MCYCLE_X2 - 1);
  localparam logic [3:0] GAP_STD            = 4'(OSC_PER_MCYCLE_STD - 1);
  localparam logic [3:0] GAP_X2             = 4'(OSC_PER_MCYCLE_X2 - 1);

  // Register addresses
  localparam logic [7:0] ADDR_P0    = 8'h80;
  localparam logic [7:0] ADDR_SP    = 8'h81;
  localparam logic [7:0] ADDR_DPL   = 8'h82;
  localparam logic [7:0] ADDR_DPH   = 8'h83;
  localparam logic [7:0] ADDR_POWER_CONTROL  = 8'h87;
  localparam logic [7:0] ADDR_TIMER01_CONTROL  = 8'h88;
  localparam logic [7:0] ADDR_TIMER01_MODE  = 8'h89;
  localparam logic [7:0] ADDR_TL0   = 8'h8a;
  localparam logic [7:0] ADDR_TL1   = 8'h8b;
  localparam logic [7:0] ADDR_TH0   = 8'h8c;
  localparam logic [7:0] ADDR_TH1   = 8'h8d;
  localparam logic [7:0] ADDR_AUX   = 8'h8e;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8f;
  localparam logic [7:0] ADDR_T2LO  = 8'hc8;
  localparam logic [7:0] ADDR_T2HI  = 8'hcd;
  localparam logic [7:0] ADDR_PSW   = 8'hd0;

  // Reset values
  localparam logic [7:0] RST_PORT = 8'hff;
  localparam logic [7:0] RST_SP   = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RD_RSVD  = 8'h00;

  // Plain storage registers: address, reset value, writable-bit mask
  localparam int SFB_NPLAIN = 23;
  localparam logic [7:0] PLAIN_ADDR [SFB_NPLAIN] = '{
    8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h89, 8'h8e, 8'h8f, 8'h90, 8'h98, 8'h99, 8'ha0,
    8'ha8, 8'hb0, 8'hb8, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'he0, 8'hf0};
  localparam logic [7:0] PLAIN_RST [SFB_NPLAIN] = '{
    8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff,
    8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] PLAIN_MASK [SFB_NPLAIN] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'h8f, 8'hff, 8'h01, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hbf, 8'hff, 8'h3f, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam int IX_P0    = 0;
  localparam int IX_SP    = 1;
  localparam int IX_TIMER01_MODE  = 5;
  localparam int IX_AUX   = 6;
  localparam int IX_CLOCK_CONTROL = 7;
  localparam int IX_P1    = 8;
  localparam int IX_P2    = 11;
  localparam int IX_IE    = 12;
  localparam int IX_P3    = 13;
  localparam int IX_ACC   = 21;

  // Field positions
  localparam int TC_TF1 = 7;
  localparam int TC_TR1 = 6;
  localparam int TC_TF0 = 5;
  localparam int TC_TR0 = 4;
  localparam int TC_IE1 = 3;
  localparam int TC_IT1 = 2;
  localparam int TC_IE0 = 1;
  localparam int TC_IT0 = 0;
  localparam int TM_T1_LSB  = 4;
  localparam int TM_GATE    = 3;
  localparam int TM_CT      = 2;
  localparam int IE_RSVD    = 6;
  localparam int PSW_PARITY = 0;
  localparam int CK_X2      = 0;
  localparam int AUX_ALE    = 0;
  localparam int BIT_LSB    = 3;
  localparam logic [7:0] PSW_MASK = 8'hfe;

  // Mode-0 prescaler
  localparam int         PRE_W   = 5;
  localparam logic [4:0] PRE_MAX = 5'h1f;

  // Pin vector positions
  localparam int PIN_T0   = 0;
  localparam int PIN_T1   = 1;
  localparam int PIN_INT0 = 2;
  localparam int PIN_INT1 = 3;
  localparam int PIN_EXT  = 4;

  typedef enum logic [1:0] {
    SFB_TM_PRESCALE = 2'b00,
    SFB_TM_16BIT    = 2'b01,
    SFB_TM_RELOAD   = 2'b10,
    SFB_TM_SPLIT    = 2'b11
  } sfb_tmode_t;

endpackage : sfb_pkg

// ### src/sfb_clkgen.sv
// Clock generator: divide-by-two stage with double-speed bypass, machine-cycle enable.
// Assumes clk_in is the oscillator; the speed request comes from a register on clk_in.
`timescale 1ns/1ps
module sfb_clkgen (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // Speed request
  input  wire logic x2_req_in,
  // Timing outputs
  output logic      x2_active_out,
  output logic      mcycle_out
);
  import sfb_pkg::*;

  logic       half_q;
  logic       x2_q;
  logic [2:0] phase_q;
  logic       mcycle_q;
  logic       phase_tick;

  assign phase_tick    = x2_q | half_q;
  assign x2_active_out = x2_q;
  assign mcycle_out    = mcycle_q;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) half_q <= 1'b0;
    else half_q <= ~half_q;
  end

  // Take the request only where the halved clock rises
  always_ff @(posedge clk_in) begin
    if (!rstn_in) x2_q <= 1'b0;
    else if (!half_q) x2_q <= x2_req_in;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) phase_q <= 3'h0;
    else if (phase_tick) phase_q <= (phase_q == PHASE_LAST) ? 3'h0 : phase_q + 3'h1;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) mcycle_q <= 1'b0;
    else mcycle_q <= phase_tick && (phase_q == PHASE_LAST);
  end

  // Helper: gap between machine cycles while the mode stays put
  logic [3:0] gap_q;
  logic       flip_q;
  logic       flip_prev_q;
  logic       seen_q;
  always_ff @(posedge clk_in) begin
    if (!rstn_in || mcycle_q) gap_q <= 4'h0;
    else gap_q <= gap_q + 4'h1;
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      flip_q      <= 1'b0;
      flip_prev_q <= 1'b0;
      seen_q      <= 1'b0;
    end else begin
      if (mcycle_q) begin
        flip_prev_q <= flip_q;
        flip_q      <= 1'b0;
        seen_q      <= 1'b1;
      end
      if ($changed(x2_q)) flip_q <= 1'b1;
    end
  end

  a_std_period : assert property (@(posedge clk_in) disable iff (!rstn_in)
    (mcycle_q && seen_q && !x2_q && !flip_q && !flip_prev_q) |-> gap_q == GAP_STD)
    else $error("standard machine cycle not 12 clocks");
  a_x2_period : assert property (@(posedge clk_in) disable iff (!rstn_in)
    (mcycle_q && seen_q && x2_q && !flip_q && !flip_prev_q) |-> gap_q == GAP_X2)
    else $error("double-speed machine cycle not 6 clocks");
  a_x2_edge_only : assert property (@(posedge clk_in) disable iff (!rstn_in)
    $changed(x2_q) |-> $past(half_q) == 1'b0)
    else $error("speed mode changed off the halved clock edge");

endmodule : sfb_clkgen

// ### src/sfb_regbank.sv
// Top of the register bank: direct-address byte port, bit-address port, timers 0/1.
// Assumes the core drives the address ports on clk_in; pins arrive asynchronously.
`timescale 1ns/1ps
module sfb_regbank #(
  parameter bit HAS_TIMER2 = 1'b1
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // Byte access
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  // Bit access
  input  wire logic [7:0] bit_addr_in,
  input  wire logic       bit_wr_in,
  input  wire logic       bit_wdata_in,
  output logic            bit_rdata_out,
  // Pins
  input  wire logic       t0_pin_in,
  input  wire logic       t1_pin_in,
  input  wire logic       int0_pin_in,
  input  wire logic       int1_pin_in,
  input  wire logic       ext_exec_in,
  // Port latches and control outputs
  output logic      [7:0] port0_out,
  output logic      [7:0] port1_out,
  output logic      [7:0] port2_out,
  output logic      [7:0] port3_out,
  output logic            ale_suppress_out,
  output logic            double_speed_out,
  output logic            machine_cycle_out
);
  import sfb_pkg::*;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  logic [7:0] plain_q [SFB_NPLAIN];
  logic [7:0] timer01_control_q;
  logic [7:0] tl0_q;
  logic [7:0] th0_q;
  logic [7:0] tl1_q;
  logic [7:0] th1_q;
  logic [7:1] psw_q;
  logic       parity_q;
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  logic [3:0] pin_m_q;
  logic [3:0] pin_mm_q;
  logic       mcycle;
  logic       x2_active;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] bit_byte;
  logic [3:0] pin_fall;

  function automatic logic t2_addr(input logic [7:0] a);
    return (a >= ADDR_T2LO) && (a <= ADDR_T2HI);
  endfunction : t2_addr

  function automatic logic plain_hit(input logic [7:0] a, input int i);
    return (a == PLAIN_ADDR[i]) && (HAS_TIMER2 || !t2_addr(a));
  endfunction : plain_hit

  // Byte value as seen by software
  function automatic logic [7:0] sfr_value(input logic [7:0] a);
    logic [7:0] v;
    v = RD_RSVD;
    for (int i = 0; i < SFB_NPLAIN; i++) begin
      if (plain_hit(a, i)) v = plain_q[i];
    end
    unique case (a)
      ADDR_TIMER01_CONTROL: v = timer01_control_q;
      ADDR_TL0:  v = tl0_q;
      ADDR_TH0:  v = th0_q;
      ADDR_TL1:  v = tl1_q;
      ADDR_TH1:  v = th1_q;
      ADDR_PSW:  v = {psw_q, parity_q};
      default:   v = v;
    endcase
    return v;
  endfunction : sfr_value

  function automatic logic wr_hit(input logic [7:0] a);
    return wr_en && (wr_addr == a);
  endfunction : wr_hit

  // One step of a timer in the given mode: {overflow, high, low}
  function automatic logic [16:0] tmr_step(input sfb_tmode_t md, input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [8:0]  h9;
    logic [16:0] r;
    h9 = {1'b0, hi} + 9'h001;
    r  = {1'b0, hi, lo};
    unique case (md)
      SFB_TM_PRESCALE: begin
        if (lo[PRE_W-1:0] == PRE_MAX) r = {h9, lo[7:PRE_W], 5'h00};
        else r = {1'b0, hi, lo + 8'h01};
      end
      SFB_TM_16BIT:  r = {1'b0, hi, lo} + 17'h00001;
      SFB_TM_RELOAD: r = (lo == 8'hff) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
      SFB_TM_SPLIT:  r = {(lo == 8'hff), hi, lo + 8'h01};
    endcase
    return r;
  endfunction : tmr_step

  sfb_clkgen u_clkgen (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .x2_req_in     (plain_q[IX_CLOCK_CONTROL][CK_X2]),
    .x2_active_out (x2_active),
    .mcycle_out    (mcycle)
  );

  assign machine_cycle_out = mcycle;
  assign double_speed_out  = x2_active;
  assign port0_out         = plain_q[IX_P0];
  assign port1_out         = plain_q[IX_P1];
  assign port2_out         = plain_q[IX_P2];
  assign port3_out         = plain_q[IX_P3];

  // Write path: a byte write wins over a bit write in the same cycle
  always_comb begin
    bit_byte = sfr_value({bit_addr_in[7:BIT_LSB], 3'b000});
    wr_en    = sfr_wr_in || (bit_wr_in && bit_addr_in[7]);
    wr_addr  = {bit_addr_in[7:BIT_LSB], 3'b000};
    wr_data  = bit_byte;
    wr_data[bit_addr_in[2:0]] = bit_wdata_in;
    if (sfr_wr_in) begin
      wr_addr = sfr_addr_in;
      wr_data = sfr_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sfr_rdata_out <= RST_ZERO;
      bit_rdata_out <= 1'b0;
    end else begin
      sfr_rdata_out <= sfr_value(sfr_addr_in);
      bit_rdata_out <= bit_addr_in[7] && bit_byte[bit_addr_in[2:0]];
    end
  end

  // Plain storage; reserved bits masked on write
  generate
    for (genvar g = 0; g < SFB_NPLAIN; g++) begin : g_plain
      always_ff @(posedge clk_in) begin
        if (!rstn_in) plain_q[g] <= PLAIN_RST[g];
        else if (wr_en && plain_hit(wr_addr, g))
          plain_q[g] <= wr_data & PLAIN_MASK[g];
      end
    end
  endgenerate

  // Status word; parity is hardware-owned
  always_ff @(posedge clk_in) begin
    if (!rstn_in) psw_q <= RST_ZERO[7:1];
    else if (wr_hit(ADDR_PSW)) psw_q <= wr_data[7:1] & PSW_MASK[7:1];
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) parity_q <= 1'b0;
    else parity_q <= ^plain_q[IX_ACC];
  end

  // Pin synchronisers, then per-cycle samples for edge detection
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pin_meta_q <= 5'h1f;
      pin_sync_q <= 5'h1f;
    end else begin
      pin_meta_q <= {ext_exec_in, int1_pin_in, int0_pin_in, t1_pin_in, t0_pin_in};
      pin_sync_q <= pin_meta_q;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pin_m_q  <= 4'hf;
      pin_mm_q <= 4'hf;
    end else if (mcycle) begin
      pin_m_q  <= pin_sync_q[3:0];
      pin_mm_q <= pin_m_q;
    end
  end
  assign pin_fall = pin_mm_q & ~pin_m_q;

  // Timer 0/1 tick qualification
  sfb_tmode_t  mode0;
  sfb_tmode_t  mode1;
  logic [3:0]  tm0;
  logic [3:0]  tm1;
  logic        tick0;
  logic        tick1;
  logic        tick0h;
  logic [16:0] step0;
  logic [16:0] step1;
  logic        set_tf0;
  logic        set_tf1;

  always_comb begin
    tm0    = plain_q[IX_TIMER01_MODE][TM_T1_LSB-1:0];
    tm1    = plain_q[IX_TIMER01_MODE][7:TM_T1_LSB];
    mode0  = sfb_tmode_t'(tm0[1:0]);
    mode1  = sfb_tmode_t'(tm1[1:0]);
    // ticks ride the machine-cycle enable, which follows the speed mode
    tick0  = mcycle && timer01_control_q[TC_TR0] && (!tm0[TM_GATE] || pin_sync_q[PIN_INT0])
             && (!tm0[TM_CT] || pin_fall[PIN_T0]);
    tick1  = mcycle && timer01_control_q[TC_TR1] && (!tm1[TM_GATE] || pin_sync_q[PIN_INT1])
             && (!tm1[TM_CT] || pin_fall[PIN_T1]) && (mode1 != SFB_TM_SPLIT);
    tick0h = mcycle && timer01_control_q[TC_TR1] && (mode0 == SFB_TM_SPLIT);
    step0  = tmr_step(mode0, tl0_q, th0_q);
    step1  = tmr_step(mode1, tl1_q, th1_q);
    set_tf0 = tick0 && step0[16];
    set_tf1 = (tick1 && step1[16]) || (tick0h && (th0_q == 8'hff));
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) tl0_q <= RST_ZERO;
    else if (wr_hit(ADDR_TL0)) tl0_q <= wr_data;
    else if (tick0) tl0_q <= step0[7:0];
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) th0_q <= RST_ZERO;
    else if (wr_hit(ADDR_TH0)) th0_q <= wr_data;
    else if (mode0 == SFB_TM_SPLIT) begin
      if (tick0h) th0_q <= th0_q + 8'h01;
    end else if (tick0) th0_q <= step0[15:8];
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) tl1_q <= RST_ZERO;
    else if (wr_hit(ADDR_TL1)) tl1_q <= wr_data;
    else if (tick1) tl1_q <= step1[7:0];
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) th1_q <= RST_ZERO;
    else if (wr_hit(ADDR_TH1)) th1_q <= wr_data;
    else if (tick1) th1_q <= step1[15:8];
  end

  // Timer control: hardware sets win over a software clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rstn_in) timer01_control_q <= RST_ZERO;
    else begin
      if (wr_hit(ADDR_TIMER01_CONTROL)) timer01_control_q <= wr_data;
      if (set_tf0) timer01_control_q[TC_TF0] <= 1'b1;
      if (set_tf1) timer01_control_q[TC_TF1] <= 1'b1;
      if (mcycle && (timer01_control_q[TC_IT0] ? pin_fall[PIN_INT0] : !pin_m_q[PIN_INT0]))
        timer01_control_q[TC_IE0] <= 1'b1;
      if (mcycle && (timer01_control_q[TC_IT1] ? pin_fall[PIN_INT1] : !pin_m_q[PIN_INT1]))
        timer01_control_q[TC_IE1] <= 1'b1;
    end
  end

  // Address latch suppression, inactive while running external code
  always_ff @(posedge clk_in) begin
    if (!rstn_in) ale_suppress_out <= 1'b0;
    else ale_suppress_out <= plain_q[IX_AUX][AUX_ALE] && !pin_sync_q[PIN_EXT];
  end

  // Checks
  sequence s_t0_edge;
    mcycle && pin_fall[PIN_T0];
  endsequence
  sequence s_t0_counter_armed;
    timer01_control_q[TC_TR0] && tm0[TM_CT] && !tm0[TM_GATE] && mode0 == SFB_TM_16BIT;
  endsequence

  a_reset_values : assert property ($rose(rstn_in) |->
    plain_q[IX_SP] == RST_SP && port0_out == RST_PORT && port3_out == RST_PORT
    && {psw_q, parity_q} == RST_ZERO && timer01_control_q == RST_ZERO && !double_speed_out)
    else $error("register reset values wrong");
  a_psw_parity : assert property (##1 parity_q == ^$past(plain_q[IX_ACC]))
    else $error("parity flag does not track accumulator");
  a_counter_edge : assert property ((s_t0_edge and s_t0_counter_armed)
    ##0 !wr_en |=> {th0_q, tl0_q} == $past({th0_q, tl0_q}) + 16'h0001)
    else $error("counter missed a falling edge");
  a_counter_idle : assert property ((mcycle && !pin_fall[PIN_T0]) ##0 s_t0_counter_armed
    ##0 !wr_en |=> {th0_q, tl0_q} == $past({th0_q, tl0_q}))
    else $error("counter moved without an edge");
  a_tf_set_wins : assert property (set_tf0 |=> timer01_control_q[TC_TF0])
    else $error("overflow flag lost");
  a_split_stop : assert property ((mode1 == SFB_TM_SPLIT && !wr_en)
    |=> {th1_q, tl1_q} == $past({th1_q, tl1_q}))
    else $error("timer 1 ran in split mode");
  a_reload_load : assert property ((tick0 && mode0 == SFB_TM_RELOAD && tl0_q == 8'hff
    && !wr_en) |=> tl0_q == th0_q && timer01_control_q[TC_TF0])
    else $error("auto reload wrong");
  a_ale_follow : assert property ((plain_q[IX_AUX][AUX_ALE] && !pin_sync_q[PIN_EXT])
    |=> ale_suppress_out)
    else $error("address latch suppression not applied");
  a_rsvd_bits : assert property (!plain_q[IX_IE][IE_RSVD]
    && plain_q[IX_AUX][7:1] == 7'h00 && plain_q[IX_CLOCK_CONTROL][7:1] == 7'h00)
    else $error("reserved bit took a value");
  a_bit_write : assert property ((bit_wr_in && !sfr_wr_in
    && bit_addr_in[7:BIT_LSB] == PLAIN_ADDR[IX_P1][7:BIT_LSB]) |=>
    ((port1_out ^ $past(port1_out)) & ~(8'h01 << $past(bit_addr_in[2:0]))) == 8'h00
    && port1_out[$past(bit_addr_in[2:0])] == $past(bit_wdata_in))
    else $error("bit write touched neighbouring bits");
  a_prescale_keep : assert property ((tick0 && mode0 == SFB_TM_PRESCALE && !wr_en)
    |=> tl0_q[7:PRE_W] == $past(tl0_q[7:PRE_W])
    && tl0_q[PRE_W-1:0] == $past(tl0_q[PRE_W-1:0]) + 5'h01)
    else $error("mode 0 prescaler stepped wrong");
  a_timer_tick : assert property ((mcycle && timer01_control_q[TC_TR0] && !tm0[TM_CT]
    && !tm0[TM_GATE] && mode0 == SFB_TM_16BIT && !wr_en)
    |=> {th0_q, tl0_q} == $past({th0_q, tl0_q}) + 16'h0001)
    else $error("timer missed a machine cycle");
  a_psw_write : assert property (wr_hit(ADDR_PSW) |=> psw_q == $past(wr_data[7:1]))
    else $error("status word write lost");
  a_ale_release : assert property (pin_sync_q[PIN_EXT] |=> !ale_suppress_out)
    else $error("suppression held during external execution");
  a_ext_edge : assert property ((mcycle && timer01_control_q[TC_IT0] && pin_fall[PIN_INT0])
    |=> timer01_control_q[TC_IE0])
    else $error("edge request flag not set");
  a_outputs_reset : assert property ($rose(rstn_in) |-> sfr_rdata_out == RST_ZERO
    && !bit_rdata_out && !machine_cycle_out && !ale_suppress_out && port2_out == RST_PORT)
    else $error("outputs not at reset values");

endmodule : sfb_regbank

// ### verif/test_sfb_regbank.sv
// Self-checking bench for the register bank: reset, decode, bits, parity, speed, timers.
// Assumes sfb_pkg and sfb_regbank are compiled first; bench drives all ports itself.
`timescale 1ns/1ps
module test_sfb_regbank;
  import sfb_pkg::*;
  logic       clk_in = 1'b0, rstn_in = 1'b0, sfr_wr_in = 1'b0, bit_wr_in = 1'b0;
  logic       bit_wdata_in = 1'b0, t0_pin_in = 1'b1, t1_pin_in = 1'b1;
  logic       int0_pin_in = 1'b1, int1_pin_in = 1'b1, ext_exec_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h80, sfr_wdata_in = 8'h00, bit_addr_in = 8'h80;
  logic [7:0] sfr_rdata_out, port0_out, port1_out, port2_out, port3_out;
  logic       bit_rdata_out, ale_suppress_out, double_speed_out, machine_cycle_out;
  int         fail_count = 0, n_compared = 0, cycles = 0, n;
  logic [7:0] rst_a [16] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h88, 8'h89, 8'h8a, 8'h8b,
                             8'h8c, 8'h8d, 8'h90, 8'ha0, 8'hb0, 8'hd0, 8'he0, 8'hf0};
  logic [7:0] rst_e [16] = '{8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
  logic [7:0] rsv_a [8] = '{8'h84, 8'h87, 8'h8e, 8'ha8, 8'hb8, 8'h8f, 8'hc9, 8'hff};
  logic [7:0] rsv_w [8] = '{8'hff, 8'hff, 8'hfe, 8'hff, 8'hff, 8'hfe, 8'hff, 8'hff};
  logic [7:0] rsv_e [8] = '{8'h00, 8'h8f, 8'h00, 8'hbf, 8'h3f, 8'h00, 8'h03, 8'h00};
  // Timer 0 one-tick cases per mode: low, high preload and expected result
  logic [7:0] tm_tl [4] = '{8'h1f, 8'hff, 8'hff, 8'hff};
  logic [7:0] tm_th [4] = '{8'hff, 8'hff, 8'h80, 8'h55};
  logic [7:0] tm_xl [4] = '{8'h00, 8'h00, 8'h80, 8'h00};
  logic [7:0] tm_xh [4] = '{8'h00, 8'h00, 8'h80, 8'h56};

  sfb_regbank i_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .bit_addr_in(bit_addr_in),
    .bit_wr_in(bit_wr_in), .bit_wdata_in(bit_wdata_in), .bit_rdata_out(bit_rdata_out),
    .t0_pin_in(t0_pin_in), .t1_pin_in(t1_pin_in), .int0_pin_in(int0_pin_in),
    .int1_pin_in(int1_pin_in), .ext_exec_in(ext_exec_in), .port0_out(port0_out),
    .port1_out(port1_out), .port2_out(port2_out), .port3_out(port3_out),
    .ale_suppress_out(ale_suppress_out), .double_speed_out(double_speed_out),
    .machine_cycle_out(machine_cycle_out));

  always #4 clk_in = ~clk_in;

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    sfr_addr_in  <= a;
    sfr_wr_in    <= 1'b1;
    sfr_wdata_in <= d;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
  endtask : wr

  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    sfr_addr_in <= a;
    @(posedge clk_in);
    #1 chk8(what, e, sfr_rdata_out);
  endtask : rc

  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge clk_in);
    bit_addr_in  <= a;
    bit_wr_in    <= 1'b1;
    bit_wdata_in <= v;
    @(posedge clk_in);
    bit_wr_in <= 1'b0;
  endtask : bw

  // Edges until the next machine-cycle pulse, bounded
  task automatic waitmc(output int k);
    k = 0;
    do begin
      @(posedge clk_in);
      #1 k++;
    end while (machine_cycle_out !== 1'b1 && k < 40);
  endtask : waitmc

  task automatic t_reset();
    for (int i = 0; i < 16; i++) rc("reset value", rst_a[i], rst_e[i]);
    chk8("port0", 8'hff, port0_out);
    chk8("port3", 8'hff, port3_out);
    chk8("port2", 8'hff, port2_out);
    chk1("double speed", 1'b0, double_speed_out);
    chk1("ale suppress", 1'b0, ale_suppress_out);
  endtask : t_reset

  task automatic t_reserved();
    for (int i = 0; i < 8; i++) begin
      wr(rsv_a[i], rsv_w[i]);
      rc("reserved bits", rsv_a[i], rsv_e[i]);
    end
  endtask : t_reserved

  task automatic t_parity_bits();
    wr(ADDR_SP, 8'h30);
    rc("stack pointer", ADDR_SP, 8'h30);
    wr(8'he0, 8'h07);
    rc("parity odd", ADDR_PSW, 8'h01);
    wr(8'he0, 8'h03);
    wr(ADDR_PSW, 8'hff);
    rc("status word", ADDR_PSW, 8'hfe);
    wr(ADDR_PSW, 8'h00);
    bw(8'hd7, 1'b1);
    rc("carry bit", ADDR_PSW, 8'h80);
    bw(8'h93, 1'b0);
    #1 chk8("port1 bit", 8'hf7, port1_out);
    @(posedge clk_in);
    bit_addr_in <= 8'h93;
    @(posedge clk_in);
    #1 chk1("bit read", 1'b0, bit_rdata_out);
  endtask : t_parity_bits

  task automatic t_speed();
    waitmc(n);
    waitmc(n);
    chk8("standard gap", 8'd12, 8'(n));
    wr(ADDR_CLOCK_CONTROL, 8'h01);
    waitmc(n);
    waitmc(n);
    waitmc(n);
    chk8("double gap", 8'd6, 8'(n));
    chk1("double speed on", 1'b1, double_speed_out);
    wr(ADDR_CLOCK_CONTROL, 8'h00);
    waitmc(n);
    waitmc(n);
    waitmc(n);
    chk8("back to standard", 8'd12, 8'(n));
  endtask : t_speed

  task automatic t_timers();
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_TIMER01_CONTROL, 8'h00);
      wr(ADDR_TIMER01_MODE, (m == 3) ? 8'h33 : 8'(m));
      wr(ADDR_TL0, tm_tl[m]);
      wr(ADDR_TH0, tm_th[m]);
      // Start just after a machine cycle so exactly one tick falls in the window
      waitmc(n);
      bw(8'h8c, 1'b1);
      if (m == 3) bw(8'h8e, 1'b1);
      waitmc(n);
      bw(8'h8c, 1'b0);
      bw(8'h8e, 1'b0);
      rc("timer0 low", ADDR_TL0, tm_xl[m]);
      rc("timer0 high", ADDR_TH0, tm_xh[m]);
      rc("overflow flag", ADDR_TIMER01_CONTROL, 8'h20);
    end
    wr(ADDR_TIMER01_MODE, 8'h05);
    wr(ADDR_TL0, 8'h00);
    wr(ADDR_TIMER01_CONTROL, 8'h10);
    rc("counter idle", ADDR_TL0, 8'h00);
    @(posedge clk_in);
    t0_pin_in <= 1'b0;
    repeat (60) @(posedge clk_in);
    rc("counter edge", ADDR_TL0, 8'h01);
    @(posedge clk_in);
    t0_pin_in <= 1'b1;
    wr(ADDR_TIMER01_CONTROL, 8'h00);
  endtask : t_timers

  // External request flags: edge mode on line 0, level mode on line 1, both sticky
  task automatic t_ext();
    wr(ADDR_TIMER01_CONTROL, 8'h01);
    @(posedge clk_in);
    int0_pin_in <= 1'b0;
    int1_pin_in <= 1'b0;
    repeat (40) @(posedge clk_in);
    int0_pin_in <= 1'b1;
    int1_pin_in <= 1'b1;
    repeat (40) @(posedge clk_in);
    rc("external flags", ADDR_TIMER01_CONTROL, 8'h0b);
    wr(ADDR_TIMER01_CONTROL, 8'h00);
  endtask : t_ext

  task automatic t_ale();
    wr(ADDR_AUX, 8'h01);
    repeat (3) @(posedge clk_in);
    chk1("ale off", 1'b1, ale_suppress_out);
    ext_exec_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk1("ale external", 1'b0, ale_suppress_out);
    ext_exec_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    chk1("ale after reset", 1'b0, ale_suppress_out);
    rc("aux after reset", ADDR_AUX, 8'h00);
  endtask : t_ale

  task automatic results();
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_reserved();
    t_parity_bits();
    t_speed();
    t_timers();
    t_ext();
    t_ale();
    results();
  end
endmodule : test_sfb_regbank
